// ===== disk_task_ctrl.sv
// task-file command interpreter: fill, features, identify, control
//
// Summary of operation
// - fill with feature DD writes whole area; only drive select used.
// - fill failure loads error code and failing lba; count register left as is.
// - feature 55 turns read-ahead off, AA turns it on.
// - feature BB selects four check bytes, 44 selects seven.
// - any reset restores read-ahead on and four check bytes.
// - feature command completion raises interrupt request.
// - long switch on forces seven check bytes, ignores 44 and BB.
// - identify builds sector, sets data request and raises interrupt.
// - identify words 4, 5, 6 hold 936d, 0251, 003f.
// - identify word 20 reports buffer type 0003.
// - identify word 21 reports buffer size 0080.
// - identify word 22 reports current check-byte count.
// - identify word 47 reports 0020 sectors per interrupt.
// - identify word 49 bit 8 dma; words 51, 52 hold 0100.
// - error bits: bad block 7, unc 6, idnf 4, abort 2, tk0 1, am 0.
// - status bits: ready 6, fault 5, seek done 4, corrected 2, error 0.
// - alternate status reads status without clearing interrupt.
// - soft reset bit held at one keeps task file, features, sequencer and interrupt request reset.
// - control bit1 one floats the interrupt output.
// - hardware reset clears device control to 00.
// - 3F7 reads drive address: write gate, inverted head, drive selects.
// - 16-bit indication only on pio data register access, not dma.
// - fill with feature other than 22 or DD aborts.
// - aborted condition sets error register to 04.
`timescale 1ns/1ps
`default_nettype none

module disk_task_ctrl (
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	// host task-file bus
	input  wire disk_task_pkg::host_req_t host_req,
	output var  logic [15:0]              host_rdata,
	output var  logic                     host_iocs16,
	output var  logic                     intrq_out,
	output var  logic                     intrq_oe,
	// configuration switch
	input  wire logic                     long_ecc_switch,
	// media engine
	output var  disk_task_pkg::fill_cmd_t fill_cmd,
	input  wire disk_task_pkg::fill_rsp_t fill_rsp,
	input  wire logic                     write_gate,
	input  wire logic                     drive_fault,
	input  wire logic                     seek_done,
	// feature state seen by the media engine
	output var  logic                     cache_enable,
	output var  logic [3:0]               ecc_len
);
	import disk_task_pkg::*;

	typedef enum {S_IDLE, S_FILL, S_IDENT} state_t;

	state_t      state;
	logic [7:0]  dev_ctrl;
	logic [7:0]  features;
	logic [7:0]  count;
	logic [7:0]  sector;
	logic [7:0]  cyl_lo;
	logic [7:0]  cyl_hi;
	logic [7:0]  drv_head;
	logic [7:0]  error;
	logic        busy;
	logic        drq;
	logic        err_flag;
	logic        intrq;
	logic [7:0]  word_idx;
	logic        ecc_vendor;
	logic        soft_rst;
	logic        any_rst;
	logic [7:0]  status;
	logic [15:0] ident_word;
	logic        wr_cmd;
	logic        rd_status;

	//////////////////////////////////////////////////////////////////////
	// reset and decode

	assign soft_rst  = dev_ctrl[DC_SRST];
	assign any_rst   = rst | soft_rst;
	assign wr_cmd    = host_req.wr && host_req.addr == ADDR_STATUS;
	assign rd_status = host_req.rd && host_req.addr == ADDR_STATUS;

	// only a hardware reset clears control, else soft reset would clear itself
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dev_ctrl <= DC_RESET;
		end else if (host_req.wr && host_req.addr == ADDR_ALT_CTRL) begin
			dev_ctrl <= host_req.wdata[7:0];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// parameter registers

	always_ff @(posedge core_clk) begin
		if (any_rst) begin
			features <= 8'h00;
			count    <= 8'h01;
			sector   <= 8'h01;
			cyl_lo   <= 8'h00;
			cyl_hi   <= 8'h00;
			drv_head <= 8'h00;
		end else if (state == S_FILL && fill_rsp.done && fill_rsp.fail) begin
			// failing lba reported; count register left as is
			sector   <= fill_rsp.fail_lba[7:0];
			cyl_lo   <= fill_rsp.fail_lba[15:8];
			cyl_hi   <= fill_rsp.fail_lba[23:16];
			drv_head <= {drv_head[7:4], fill_rsp.fail_lba[27:24]};
		end else if (host_req.wr && !busy) begin
			unique case (host_req.addr)
				ADDR_ERROR:    features <= host_req.wdata[7:0];
				ADDR_COUNT:    count    <= host_req.wdata[7:0];
				ADDR_SECTOR:   sector   <= host_req.wdata[7:0];
				ADDR_CYL_LO:   cyl_lo   <= host_req.wdata[7:0];
				ADDR_CYL_HI:   cyl_hi   <= host_req.wdata[7:0];
				ADDR_DRV_HEAD: drv_head <= host_req.wdata[7:0];
				default:       ;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// feature settings

	always_ff @(posedge core_clk) begin
		if (any_rst) begin
			cache_enable <= CACHE_RESET;
			ecc_vendor   <= 1'b0;
		end else if (wr_cmd && !busy && host_req.wdata[7:0] == CMD_FEATURES) begin
			unique case (features)
				FEAT_CACHE_OFF:  cache_enable <= 1'b0;
				FEAT_CACHE_ON:   cache_enable <= 1'b1;
				FEAT_ECC_VENDOR: ecc_vendor   <= 1'b1;
				FEAT_ECC_FOUR:   ecc_vendor   <= 1'b0;
				default:         ;
			endcase
		end
	end

	// switch overrides whatever the host selected
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ecc_len <= ECC_LEN_FOUR;
		end else if (long_ecc_switch) begin
			ecc_len <= ECC_LEN_SEVEN;
		end else begin
			ecc_len <= ecc_vendor ? ECC_LEN_SEVEN : ECC_LEN_FOUR;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// command sequencer

	always_ff @(posedge core_clk) begin
		if (any_rst) begin
			state    <= S_IDLE;
			busy     <= 1'b0;
			drq      <= 1'b0;
			err_flag <= 1'b0;
			error    <= 8'h00;
			word_idx <= 8'h00;
			fill_cmd <= '0;
		end else begin
			fill_cmd.start <= 1'b0;
			unique case (state)
				S_IDLE: begin
					if (wr_cmd) begin
						err_flag <= 1'b0;
						error    <= 8'h00;
						unique case (host_req.wdata[7:0])
							CMD_FILL_SAME: begin
								if (features == FEAT_FILL_WHOLE
									|| features == FEAT_FILL_RANGE) begin
									// whole mode: only drive select is meaningful
									fill_cmd.start      <= 1'b1;
									fill_cmd.whole      <= features == FEAT_FILL_WHOLE;
									// zeroed so a stale address cannot reach the engine
									if (features == FEAT_FILL_WHOLE) begin
										fill_cmd.count <= 8'h00;
										fill_cmd.lba   <= 28'h0000000;
									end else begin
										fill_cmd.count <= count;
										fill_cmd.lba   <= {drv_head[3:0], cyl_hi, cyl_lo, sector};
									end
									fill_cmd.drive_head <= {3'h0, drv_head[4]};
									busy  <= 1'b1;
									state <= S_FILL;
								end else begin
									error    <= ERR_ABORTED;
									err_flag <= 1'b1;
								end
							end
							CMD_FEATURES: begin
								if (features != FEAT_ECC_VENDOR && features != FEAT_CACHE_OFF
									&& features != FEAT_CACHE_ON && features != FEAT_ECC_FOUR) begin
									error    <= ERR_ABORTED;
									err_flag <= 1'b1;
								end
							end
							CMD_IDENTIFY: begin
								drq      <= 1'b1;
								word_idx <= 8'h00;
								state    <= S_IDENT;
							end
							default: begin
								error    <= ERR_ABORTED;
								err_flag <= 1'b1;
							end
						endcase
					end
				end
				S_FILL: begin
					if (fill_rsp.done) begin
						busy  <= 1'b0;
						state <= S_IDLE;
						if (fill_rsp.fail) begin
							error    <= fill_rsp.err_code;
							err_flag <= 1'b1;
						end
					end
				end
				S_IDENT: begin
					// host drains exactly 256 words
					if (host_req.rd && host_req.addr == ADDR_DATA && !host_req.dma_ack) begin
						word_idx <= word_idx + 8'h01;
						if (word_idx == ID_WORDS) begin
							drq   <= 1'b0;
							state <= S_IDLE;
						end
					end
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// interrupt request

	// set beats the clear from a status read in the same cycle
	always_ff @(posedge core_clk) begin
		if (any_rst) begin
			intrq <= 1'b0;
		end else if (state == S_IDLE && wr_cmd) begin
			intrq <= host_req.wdata[7:0] != CMD_FILL_SAME
				|| (features != FEAT_FILL_WHOLE && features != FEAT_FILL_RANGE);
		end else if (state == S_FILL && fill_rsp.done) begin
			intrq <= 1'b1;
		end else if (rd_status) begin
			intrq <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			intrq_out <= 1'b0;
			intrq_oe  <= 1'b1;
		end else begin
			intrq_out <= intrq;
			intrq_oe  <= !dev_ctrl[DC_NIEN];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// read path

	always_comb begin
		status          = 8'h00;
		status[ST_BSY]  = busy;
		status[ST_DRDY] = 1'b1;
		status[ST_DWF]  = drive_fault;
		status[ST_DSC]  = seek_done;
		status[ST_DRQ]  = drq;
		status[ST_CORR] = 1'b0;
		status[ST_ERR]  = err_flag;
	end

	always_comb begin
		unique case (word_idx)
			8'd4:    ident_word = ID_W4_TRKBYT;
			8'd5:    ident_word = ID_W5_SECBYT;
			8'd6:    ident_word = ID_W6_SPT;
			8'd20:   ident_word = ID_W20_BTYPE;
			8'd21:   ident_word = ID_W21_BSIZE;
			8'd22:   ident_word = {12'h000, ecc_len};
			8'd47:   ident_word = ID_W47_MULT;
			8'd49:   ident_word = ID_W49_CAPS;
			8'd51:   ident_word = ID_W51_PIO;
			8'd52:   ident_word = ID_W52_DMA;
			default: ident_word = 16'h0000;
		endcase
	end

	// read data registered: valid the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (rst) begin
			host_rdata <= 16'h0000;
		end else if (host_req.rd) begin
			unique case (host_req.addr)
				ADDR_DATA:     host_rdata <= state == S_IDENT ? ident_word : 16'h0000;
				ADDR_ERROR:    host_rdata <= {8'h00, error};
				ADDR_COUNT:    host_rdata <= {8'h00, count};
				ADDR_SECTOR:   host_rdata <= {8'h00, sector};
				ADDR_CYL_LO:   host_rdata <= {8'h00, cyl_lo};
				ADDR_CYL_HI:   host_rdata <= {8'h00, cyl_hi};
				ADDR_DRV_HEAD: host_rdata <= {8'h00, drv_head};
				ADDR_STATUS:   host_rdata <= {8'h00, status};
				ADDR_ALT_CTRL: host_rdata <= {8'h00, status};
				// bit7 undriven on the bus, reads as zero here
				ADDR_DRV_ADDR: host_rdata <= {8'h00, 1'b0, write_gate, ~drv_head[3:0],
					~drv_head[4], drv_head[4]};
				default:       host_rdata <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			host_iocs16 <= 1'b0;
		end else begin
			host_iocs16 <= (host_req.rd || host_req.wr) && host_req.addr == ADDR_DATA
				&& !host_req.dma_ack;
		end
	end

endmodule : disk_task_ctrl

`default_nettype wire

// ===== disk_task_pkg.sv
// package: task-file offsets, field positions, feature codes, identify layout
package disk_task_pkg;

	// task-file addresses (host i/o space)
	localparam logic [9:0] ADDR_DATA      = 10'h1f0;
	localparam logic [9:0] ADDR_ERROR     = 10'h1f1;
	localparam logic [9:0] ADDR_COUNT     = 10'h1f2;
	localparam logic [9:0] ADDR_SECTOR    = 10'h1f3;
	localparam logic [9:0] ADDR_CYL_LO    = 10'h1f4;
	localparam logic [9:0] ADDR_CYL_HI    = 10'h1f5;
	localparam logic [9:0] ADDR_DRV_HEAD  = 10'h1f6;
	localparam logic [9:0] ADDR_STATUS    = 10'h1f7;
	localparam logic [9:0] ADDR_ALT_CTRL  = 10'h3f6;
	localparam logic [9:0] ADDR_DRV_ADDR  = 10'h3f7;

	// command codes
	localparam logic [7:0] CMD_FILL_SAME  = 8'he9;
	localparam logic [7:0] CMD_FEATURES   = 8'hef;
	localparam logic [7:0] CMD_IDENTIFY   = 8'hec;

	// feature values
	localparam logic [7:0] FEAT_FILL_RANGE = 8'h22;
	localparam logic [7:0] FEAT_FILL_WHOLE = 8'hdd;
	localparam logic [7:0] FEAT_ECC_VENDOR = 8'h44;
	localparam logic [7:0] FEAT_CACHE_OFF  = 8'h55;
	localparam logic [7:0] FEAT_CACHE_ON   = 8'haa;
	localparam logic [7:0] FEAT_ECC_FOUR   = 8'hbb;

	// error register bits
	localparam int ERR_BBK   = 7;
	localparam int ERR_UNC   = 6;
	localparam int ERR_IDNF  = 4;
	localparam int ERR_ABRT  = 2;
	localparam int ERR_TK0NF = 1;
	localparam int ERR_AMNF  = 0;
	localparam logic [7:0] ERR_ABORTED = 8'h04;

	// status register bits
	localparam int ST_BSY  = 7;
	localparam int ST_DRDY = 6;
	localparam int ST_DWF  = 5;
	localparam int ST_DSC  = 4;
	localparam int ST_DRQ  = 3;
	localparam int ST_CORR = 2;
	localparam int ST_ERR  = 0;

	// device control bits
	localparam int DC_SRST = 2;
	localparam int DC_NIEN = 1;
	localparam logic [7:0] DC_RESET = 8'h00;

	// reset values of features
	localparam logic       CACHE_RESET = 1'b1;
	localparam logic [3:0] ECC_LEN_FOUR  = 4'h4;
	localparam logic [3:0] ECC_LEN_SEVEN = 4'h7;

	// identify sector
	localparam logic [7:0]  ID_WORDS     = 8'hff;
	localparam logic [15:0] ID_W4_TRKBYT = 16'h936d;
	localparam logic [15:0] ID_W5_SECBYT = 16'h0251;
	localparam logic [15:0] ID_W6_SPT    = 16'h003f;
	localparam logic [15:0] ID_W20_BTYPE = 16'h0003;
	localparam logic [15:0] ID_W21_BSIZE = 16'h0080;
	localparam logic [15:0] ID_W47_MULT  = 16'h0020;
	localparam logic [15:0] ID_W49_CAPS  = 16'h0100;
	localparam logic [15:0] ID_W51_PIO   = 16'h0100;
	localparam logic [15:0] ID_W52_DMA   = 16'h0100;

	// host bus request
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [9:0] addr;
		logic [15:0] wdata;
		logic       dma_ack;
	} host_req_t;

	// media engine interface
	typedef struct packed {
		logic        start;
		logic        whole;
		logic [7:0]  count;
		logic [27:0] lba;
		logic [3:0]  drive_head;
	} fill_cmd_t;

	typedef struct packed {
		logic        done;
		logic        fail;
		logic [7:0]  err_code;
		logic [27:0] fail_lba;
	} fill_rsp_t;

endpackage : disk_task_pkg

// ===== disk_task_ctrl_chk.sv
// checker: port properties of the task-file interpreter
`timescale 1ns/1ps
`default_nettype none
module disk_task_ctrl_chk
	import disk_task_pkg::*;
(
	// clock and reset
	input wire logic                     core_clk,
	input wire logic                     rst,
	// watched ports
	input wire disk_task_pkg::host_req_t host_req,
	input wire logic                     host_iocs16,
	input wire logic                     intrq_out,
	input wire logic                     intrq_oe,
	input wire logic                     long_ecc_switch,
	input wire logic                     cache_enable,
	input wire logic [3:0]               ecc_len
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [7:0] feat_q;
	logic       fc;
	logic       srst_q;
	// shadow of the soft reset bit: commands and features are ignored while set
	always_ff @(posedge core_clk) begin
		if (rst) begin
			srst_q <= 1'b0;
		end else if (host_req.wr && host_req.addr == ADDR_ALT_CTRL) begin
			srst_q <= host_req.wdata[DC_SRST];
		end
	end
	// shadow of the features value, host always loads it first
	always_ff @(posedge core_clk) begin
		if (rst || srst_q) begin
			feat_q <= 8'h00;
		end else if (host_req.wr && host_req.addr == ADDR_ERROR) begin
			feat_q <= host_req.wdata[7:0];
		end
	end
	assign fc = host_req.wr && host_req.addr == ADDR_STATUS && !srst_q
		&& host_req.wdata[7:0] == CMD_FEATURES;
	////////////////////////////////////////////////////////////////////////////////
	AST_CACHE_OFF: assert property (fc && feat_q == FEAT_CACHE_OFF |-> ##[1:3] !cache_enable)
		else $error("read-ahead not disabled");
	AST_ECC_FOUR: assert property (fc && feat_q == FEAT_ECC_FOUR && !long_ecc_switch
		|-> ##[1:3] ecc_len == ECC_LEN_FOUR) else $error("check length not four");
	AST_LONG_SW: assert property (long_ecc_switch [*3] |-> ecc_len == ECC_LEN_SEVEN)
		else $error("switch did not force seven");
	AST_RST_DEF: assert property ($past(rst) |-> cache_enable && ecc_len == ECC_LEN_FOUR && intrq_oe)
		else $error("bad defaults after reset");
	AST_FEAT_IRQ: assert property (fc && intrq_oe |-> ##[1:3] intrq_out)
		else $error("no interrupt after feature command");
	AST_NIEN: assert property (host_req.wr && host_req.addr == ADDR_ALT_CTRL
		|-> ##2 intrq_oe != $past(host_req.wdata[DC_NIEN], 2))
		else $error("enable not following bit1");
	AST_ALT_KEEP: assert property (intrq_out && host_req.rd && host_req.addr == ADDR_ALT_CTRL
		&& !host_req.wr |=> intrq_out) else $error("alternate read cleared interrupt");
	AST_IOCS_PIO: assert property (host_req.rd && host_req.addr == ADDR_DATA && !host_req.dma_ack
		|=> host_iocs16) else $error("no 16-bit indication");
	AST_IOCS_CAUSE: assert property (host_iocs16 |-> $past(host_req.addr) == ADDR_DATA
		&& !$past(host_req.dma_ack)) else $error("16-bit indication without cause");
	COV_FEAT: cover property (fc ##[1:3] intrq_out);
	COV_NIEN: cover property (host_req.wr && host_req.addr == ADDR_ALT_CTRL ##2 !intrq_oe);
	COV_DMA: cover property (host_req.rd && host_req.dma_ack);
endmodule : disk_task_ctrl_chk
bind disk_task_ctrl disk_task_ctrl_chk chk_u (.core_clk(core_clk), .rst(rst), .host_req(host_req),
	.host_iocs16(host_iocs16), .intrq_out(intrq_out), .intrq_oe(intrq_oe),
	.long_ecc_switch(long_ecc_switch), .cache_enable(cache_enable), .ecc_len(ecc_len));
`default_nettype wire

// ===== disk_media_model.sv
// partner: media engine answering fill requests
`timescale 1ns/1ps
`default_nettype none
module disk_media_model
	import disk_task_pkg::*;
(
	// clock and reset
	input wire logic                     core_clk,
	input wire logic                     rst,
	// fill traffic
	input wire disk_task_pkg::fill_cmd_t fill_cmd,
	output var disk_task_pkg::fill_rsp_t fill_rsp,
	output var disk_task_pkg::fill_cmd_t last_cmd,
	// scenario knobs
	input wire logic                     fail_en,
	input wire logic [7:0]               fail_code,
	input wire logic [27:0]              fail_lba,
	input wire logic [5:0]               lat
);
	logic [5:0] cnt;
	logic       busy;
	// fields carry junk outside the done pulse, the block must not sample them
	always_ff @(posedge core_clk) begin
		fill_rsp <= {1'b0, ~fail_en, ~fail_code, ~fail_lba};
		if (rst) begin
			busy <= 1'b0;
			cnt  <= 6'h00;
		end else if (fill_cmd.start) begin
			busy     <= 1'b1;
			cnt      <= lat;
			last_cmd <= fill_cmd;
		end else if (busy) begin
			cnt <= cnt - 6'h01;
			if (cnt == 6'h00) begin
				busy     <= 1'b0;
				fill_rsp <= {1'b1, fail_en, fail_code, fail_lba};
			end
		end
	end
endmodule : disk_media_model
`default_nettype wire

// ===== tb_disk_task_file_features_control.sv
// testbench: task-file interpreter against media model
`timescale 1ns/1ps
`default_nettype none
module tb_disk_task_file_features_control;
	import disk_task_pkg::*;
	logic        core_clk = 1'b0, rst = 1'b1, rd_d = 1'b0;
	host_req_t   host_req = '0;
	logic [15:0] host_rdata;
	logic        host_iocs16, intrq_out, intrq_oe, cache_enable;
	logic        long_ecc_switch = 1'b0, write_gate = 1'b0, drive_fault = 1'b0, seek_done = 1'b1;
	logic [27:0] fail_lba = '0;
	logic [5:0]  lat = 6'h00;
	logic [3:0]  ecc_len;
	fill_cmd_t   fill_cmd, last_cmd;
	fill_rsp_t   fill_rsp;
	logic [31:0] exp_q[$];
	logic [31:0] e, x;
	logic [7:0]  fv[4] = '{8'h55, 8'haa, 8'h44, 8'hbb};
	logic [15:0] fx[4] = '{16'h0009, 16'h0029, 16'h002f, 16'h0029};
	int          n_fail = 0, tests_run = 0;
	always #5 core_clk = ~core_clk;
	disk_task_ctrl dut_u (.core_clk(core_clk), .rst(rst), .host_req(host_req),
		.host_rdata(host_rdata), .host_iocs16(host_iocs16), .intrq_out(intrq_out),
		.intrq_oe(intrq_oe), .long_ecc_switch(long_ecc_switch), .fill_cmd(fill_cmd),
		.fill_rsp(fill_rsp), .write_gate(write_gate), .drive_fault(drive_fault),
		.seek_done(seek_done), .cache_enable(cache_enable), .ecc_len(ecc_len));
	disk_media_model media_u (.core_clk(core_clk), .rst(rst), .fill_cmd(fill_cmd),
		.fill_rsp(fill_rsp), .last_cmd(last_cmd), .fail_en(1'b1), .fail_code(8'h10),
		.fail_lba(fail_lba), .lat(lat));
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		tests_run++;
		if (got !== want) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : chk
	task automatic stop_test();
		$display("compares %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge core_clk);
		host_req.wr <= 1'b1;
		host_req.addr <= a;
		host_req.wdata <= {8'h00, d};
		@(posedge core_clk);
		host_req.wr <= 1'b0;
	endtask : wr
	// read data is judged by the monitor one cycle later, masked
	task automatic rd(input logic [9:0] a, input logic [15:0] m, input logic [15:0] v,
		input logic dma = 1'b0);
		@(posedge core_clk);
		host_req.rd <= 1'b1;
		host_req.addr <= a;
		host_req.dma_ack <= dma;
		exp_q.push_back({m, v & m});
		@(posedge core_clk);
		host_req.rd <= 1'b0;
		host_req.dma_ack <= 1'b0;
	endtask : rd
	task automatic feat(input logic [7:0] f, input logic [7:0] c);
		wr(ADDR_ERROR, f);
		wr(ADDR_STATUS, c);
		tick(3);
	endtask : feat
	always @(posedge core_clk) begin
		if (rd_d) begin
			x = exp_q.pop_front();
			chk(host_rdata & x[31:16], x[15:0]);
		end
		rd_d <= host_req.rd;
	end
	initial begin
		e = $urandom(2);
		tick(4);
		rst <= 1'b0;
		tick(2);
		chk(16'({cache_enable, ecc_len, intrq_oe}), 16'h0029);
		foreach (fv[i]) begin
			feat(fv[i], CMD_FEATURES);
			chk(16'({cache_enable, ecc_len, intrq_out}), fx[i]);
			rd(ADDR_ALT_CTRL, 16'h0031, 16'h0010);
			tick(1);
			chk(16'(intrq_out), 16'h0001);
			rd(ADDR_STATUS, 16'h0001, 16'h0000);
			tick(2);
			chk(16'(intrq_out), 16'h0000);
		end
		$display("features done");
		e = $urandom;
		feat((e[7:0] inside {fv}) ? 8'h01 : e[7:0], CMD_FEATURES);
		drive_fault <= 1'b1;
		rd(ADDR_ERROR, 16'h00ff, 16'(ERR_ABORTED));
		rd(ADDR_STATUS, 16'h0031, 16'h0031);
		drive_fault <= 1'b0;
		feat(8'h33, CMD_FILL_SAME);
		rd(ADDR_ERROR, 16'h00ff, 16'h0004);
		write_gate <= 1'b1;
		wr(ADDR_DRV_HEAD, 8'h1a);
		rd(ADDR_DRV_ADDR, 16'h007f, 16'h0055);
		$display("aborts done");
		long_ecc_switch <= 1'b1;
		feat(FEAT_ECC_FOUR, CMD_FEATURES);
		chk(16'(ecc_len), 16'h0007);
		wr(ADDR_STATUS, CMD_IDENTIFY);
		tick(3);
		chk(16'(intrq_out), 16'h0001);
		rd(ADDR_STATUS, 16'h0008, 16'h0008);
		for (int w = 0; w < 256; w++) begin
			case (w)
				4: x = 32'hffff_936d;
				5: x = 32'hffff_0251;
				6: x = 32'hffff_003f;
				20: x = 32'hffff_0003;
				21: x = 32'hffff_0080;
				22: x = 32'hffff_0007;
				47: x = 32'hffff_0020;
				49, 51, 52: x = 32'hffff_0100;
				default: x = 32'h0;
			endcase
			rd(ADDR_DATA, x[31:16], x[15:0]);
		end
		rd(ADDR_STATUS, 16'h0008, 16'h0000);
		long_ecc_switch <= 1'b0;
		rd(ADDR_DATA, 16'h0000, 16'h0000, 1'b1);
		tick(1);
		chk(16'(host_iocs16), 16'h0000);
		$display("identify done");
		feat(FEAT_CACHE_ON, CMD_FEATURES);
		wr(ADDR_ALT_CTRL, 8'h04);
		feat(FEAT_CACHE_OFF, CMD_FEATURES);
		chk(16'({cache_enable, intrq_out}), 16'h0002);
		wr(ADDR_ALT_CTRL, 8'h02);
		tick(2);
		chk(16'({cache_enable, intrq_oe}), 16'h0002);
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(2);
		chk(16'(intrq_oe), 16'h0001);
		$display("control done");
		e = $urandom;
		fail_lba <= e[27:0];
		lat <= 6'(e[31:28]);
		wr(ADDR_DRV_HEAD, 8'h13);
		feat(FEAT_FILL_WHOLE, CMD_FILL_SAME);
		for (int k = 0; intrq_out !== 1'b1; k++) begin
			if (k == 200) begin
				n_fail++;
				stop_test();
			end
			tick(1);
		end
		chk(16'({last_cmd.whole, last_cmd.drive_head[0]}), 16'h0003);
		chk(16'({last_cmd.count, last_cmd.lba[27:24]}), 16'h0000);
		rd(ADDR_ERROR, 16'h00ff, 16'h0010);
		for (int i = 0; i < 4; i++) begin
			rd(ADDR_SECTOR + 10'(i), (i == 3) ? 16'h000f : 16'h00ff, 16'(e[8 * i +: 8]));
		end
		tick(2);
		$display("fill done");
		stop_test();
	end
endmodule : tb_disk_task_file_features_control
`default_nettype wire
